// ==== bench/stt_timers_bench.sv ====
/*
  Self-checking bench for the three-timer block, APB master and pins.
  Assumes the constants header on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "stt_defs.svh"
module stt_timers_bench;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, cpu_idle, err, pin_run;
  logic primary_event, second_event, third_event, conv_trigger;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv, d, c1;
  logic [2:0] ext_pin, gate_pin;
  logic [15:0] second_time_base, third_time_base, snap;
  logic [3:0] evs;
  logic [7:0] ctl [3];
  logic [15:0] mask [3];
  int divs [4] = '{1, 8, 64, 256};
  int num_errors, n_compared, seed, ev_n, pc, conv_cnt, sec_cnt;

  stt_timers dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_idle(cpu_idle), .primary_external_clock_pin(ext_pin[0]),
    .second_external_clock_pin(ext_pin[1]), .third_external_clock_pin(ext_pin[2]),
    .primary_gate_pin(gate_pin[0]), .second_gate_pin(gate_pin[1]), .third_gate_pin(gate_pin[2]),
    .primary_event(primary_event), .second_event(second_event), .third_event(third_event),
    .conv_trigger(conv_trigger), .second_time_base(second_time_base),
    .third_time_base(third_time_base));
  assign evs = {conv_trigger, third_event, second_event, primary_event};

  // ==========================================================
  // Clock, pin clocks (rise every 6 cycles) and event counters
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    pc <= (pc == 2) ? 0 : pc + 1;
    if (pin_run && pc == 2) ext_pin <= ~ext_pin;
    if (conv_trigger === 1'b1) conv_cnt++;
    if (second_event === 1'b1) sec_cnt++;
  end

  // ==========================================================
  // Compare, closing and APB tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  task automatic ran_out();
    num_errors++;
    $display("wrong value at %0t: wait ran out", $time);
    conclude();
  endtask : ran_out
  // Holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) ran_out();
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask : wr
  task automatic wait_ev(input int k);
    ev_n = 0;
    repeat (5000) begin
      @(posedge mclk);
      #1;
      ev_n++;
      if (evs[k] === 1'b1) return;
    end
    ran_out();
  endtask : wait_ev
  // Cycles between two pulses, free of start-up latency
  task automatic interval(input int k);
    wait_ev(k);
    wait_ev(k);
  endtask : interval
  task automatic hold_check();
    // Let a step launched on the stopping edge settle first
    repeat (2) @(posedge mclk);
    #1;
    snap = second_time_base;
    // Odd span so a running counter of period four cannot alias back
    repeat (21) @(posedge mclk);
    #1;
    chk({16'h0, second_time_base}, {16'h0, snap});
  endtask : hold_check

  // ==========================================================
  // Main sequence
  initial begin
    seed = 91;
    {num_errors, n_compared, conv_cnt, sec_cnt, pc} = '0;
    {rst_n, psel, penable, pwrite, cpu_idle, pin_run} = '0;
    {paddr, pwdata, ext_pin, gate_pin} = '0;
    ctl = '{`STT_OFS_PRIMARY_CTL, `STT_OFS_SECOND_CTL, `STT_OFS_THIRD_CTL};
    mask = '{`STT_PRIMARY_MASK, `STT_SECOND_MASK, `STT_THIRD_MASK};
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    // Reset values and writable bits, run kept clear
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, ctl[i], 0); chk(rdv, 0);
      apb(1'b0, ctl[i] + 8'h04, 0); chk(rdv, 0);
      apb(1'b0, ctl[i] + 8'h08, 0); chk(rdv, 32'h0000_FFFF);
      d = $random(seed);
      wr(ctl[i], d & 32'h0000_7FFF);
      apb(1'b0, ctl[i], 0); chk(rdv, {16'h0, d[15:0] & mask[i] & 16'h7FFF});
      wr(ctl[i], 0);
    end
    apb(1'b0, 8'h24, 0); chk({rdv[30:0], err}, 1);
    apb(1'b1, 8'h26, 32'h0000_8000); chk({31'h0, err}, 1);
    $display("registers done");
    // Prescale ratios on all three timers, period 3
    for (int i = 0; i < 3; i++) wr(ctl[i] + 8'h08, 32'h3);
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < 3; i++) wr(ctl[i], 32'h8000 | (p << 4));
      for (int i = 0; i < 3; i++) begin
        interval(i); chk(ev_n, 4 * divs[p]);
      end
    end
    chk(conv_cnt, 0);
    $display("prescale done");
    // Stop, idle stop and idle run
    wr(`STT_OFS_SECOND_CTL, 0);
    hold_check();
    wr(`STT_OFS_SECOND_CTL, 32'hA000);
    cpu_idle <= 1'b1;
    repeat (4) @(posedge mclk);
    hold_check();
    wr(`STT_OFS_SECOND_CTL, 32'h8000);
    interval(1); chk(ev_n, 4);
    cpu_idle <= 1'b0;
    $display("idle done");
    // Pin clocks, gate bit ignored, both sync settings
    pin_run <= 1'b1;
    wr(`STT_OFS_PRIMARY_CTL, 32'h8042);
    interval(0); chk(ev_n, 24);
    wr(`STT_OFS_PRIMARY_CTL, 32'h8006);
    interval(0); chk(ev_n, 24);
    wr(`STT_OFS_SECOND_CTL, 32'h8042);
    wr(`STT_OFS_THIRD_CTL, 32'h8002);
    interval(1); chk(ev_n, 24);
    interval(2); chk(ev_n, 24);
    pin_run <= 1'b0;
    $display("pin clock done");
    // Gated accumulation and gate fall event on the primary timer
    wr(`STT_OFS_PRIMARY_PER, 32'hFFFF);
    wr(`STT_OFS_PRIMARY_CNT, 0);
    wr(`STT_OFS_PRIMARY_CTL, 32'h8040);
    apb(1'b0, `STT_OFS_PRIMARY_CNT, 0); chk(rdv, 0);
    gate_pin[0] <= 1'b1;
    repeat (10) @(posedge mclk);
    apb(1'b0, `STT_OFS_PRIMARY_CNT, 0);
    c1 = rdv;
    repeat (10) @(posedge mclk);
    apb(1'b0, `STT_OFS_PRIMARY_CNT, 0); chk(rdv - c1, 13);
    gate_pin[0] <= 1'b0;
    wait_ev(0); chk({31'h0, ev_n < 10}, 1);
    $display("gate done");
    // Joined pair: high word carry, third control ignored
    for (int i = 0; i < 3; i++) wr(ctl[i], 0);
    wr(`STT_OFS_SECOND_PER, 32'h5);
    wr(`STT_OFS_THIRD_PER, 32'h2);
    wr(`STT_OFS_SECOND_CNT, 32'hFFFD);
    wr(`STT_OFS_THIRD_CNT, 32'h1);
    wr(`STT_OFS_THIRD_CTL, 32'h0032);
    {conv_cnt, sec_cnt} = '0;
    wr(`STT_OFS_SECOND_CTL, 32'h8008);
    wait_ev(2); chk(ev_n, (32'h0002_0005 - 32'h0001_FFFD + 1) + 1);
    chk({third_time_base, second_time_base}, 32'h1);
    wr(`STT_OFS_SECOND_PER, 32'h3);
    wr(`STT_OFS_THIRD_PER, 32'h0);
    // Count has passed the new period; restart it below the match
    wr(`STT_OFS_SECOND_CNT, 0);
    interval(3); chk(ev_n, 4);
    chk(sec_cnt, 0);
    wr(`STT_OFS_SECOND_CTL, 32'h0008);
    hold_check();
    chk({16'h0, third_time_base}, {16'h0, snap >> 16});
    $display("joined done");
    conclude();
  end
endmodule : stt_timers_bench
`default_nettype wire

// ==== bench/stt_timers_checker.sv ====
/*
  Port checker for the three-timer block: APB answer and event timing.
  Assumes binding to stt_timers; sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module stt_timers_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Events and time bases
  input wire logic second_event,
  input wire logic third_event,
  input wire logic conv_trigger,
  input wire logic [15:0] second_time_base,
  input wire logic [15:0] third_time_base
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // APB steps: setup, one access cycle, then idle
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  a_ready_once: assert property (s_setup |=> s_access ##1 !pready)
    else $error("pready not a single access cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_zero: assert property (pslverr |-> prdata == 32'h0000_0000)
    else $error("refused access returned data");
  a_rdata_high: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");

  // ==========================================================
  // Events: count reads zero one edge earlier, trigger leads its event
  a_conv_third: assert property (conv_trigger |=> third_event)
    else $error("trigger without joined event");
  a_joined_quiet: assert property (conv_trigger |-> !second_event)
    else $error("low word event in joined mode");
  a_second_wrap: assert property (second_event |-> $past(second_time_base) == 16'h0000)
    else $error("second event without wrap");
  a_third_wrap: assert property (third_event |-> $past(third_time_base) == 16'h0000)
    else $error("third event without wrap");
endmodule : stt_timers_checker

bind stt_timers stt_timers_checker u_checker (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .second_event(second_event),
  .third_event(third_event), .conv_trigger(conv_trigger), .second_time_base(second_time_base),
  .third_time_base(third_time_base));
`default_nettype wire

// ==== rtl/stt_defs.svh ====
/*
  Constants of the three-timer block: register offsets, control field
  positions, write masks, reset values and prescale terminal counts.
  Assumes inclusion by bare name from every timer source file.
*/
// Function
// - Primary timer counts while run_control (bit 15) is set, halts when clear.
// - idle_stop (bit 13) set suspends the timer while the device idles.
// - gated_accumulate_enable (bit 6) acts only with the internal clock selected.
// - prescale_select (bits 5-4) divides the input clock by 1, 8, 64, 256.
// - With external clock, bit 2 picks synchronised or direct pin clock.
// - clock_source_select (bit 1) picks pin rising edges or instruction clock.
// - Second and third timers count their own pin edges or instruction clock.
// - combine_mode (second control bit 3) joins second and third into 32 bits.
// - Joined pair: second timer is low word, third timer high word.
// - Joined period: third period upper word, second period lower word.
// - Joined pair ignores third control; event comes out as third event.
// - Second run bit starts or stops the pair, or only the second timer.
// - Second and third timers offer no external clock synchronisation select.
// - Joined pair raises its event when 32-bit count matches 32-bit period.
// - Converter trigger only from the joined pair; time bases from second/third.
// - Second and third counts are offered as 16-bit time bases.
// - Unimplemented control bits read back as zero.
// - All control bits clear at reset, all timers stopped.
// - Primary timer signals on period match or falling gate edge.
// - Count equal to period returns to zero and keeps counting.
`ifndef STT_DEFS_SVH
`define STT_DEFS_SVH

// ==========================================================
// Register byte offsets
`define STT_OFS_PRIMARY_CTL 8'h00
`define STT_OFS_PRIMARY_CNT 8'h04
`define STT_OFS_PRIMARY_PER 8'h08
`define STT_OFS_SECOND_CTL 8'h0C
`define STT_OFS_SECOND_CNT 8'h10
`define STT_OFS_SECOND_PER 8'h14
`define STT_OFS_THIRD_CTL 8'h18
`define STT_OFS_THIRD_CNT 8'h1C
`define STT_OFS_THIRD_PER 8'h20

// ==========================================================
// Control field positions
`define STT_RUN_BIT 15
`define STT_IDLE_STOP_BIT 13
`define STT_GATE_BIT 6
`define STT_PSC_HI 5
`define STT_PSC_LO 4
`define STT_COMBINE_BIT 3
`define STT_SYNC_BIT 2
`define STT_SRC_BIT 1

// ==========================================================
// Writable masks and reset values
`define STT_PRIMARY_MASK 16'hA076
`define STT_SECOND_MASK 16'hA07A
`define STT_THIRD_MASK 16'hA072
`define STT_CTL_RESET 16'h0000
`define STT_CNT_RESET 16'h0000
`define STT_PER_RESET 16'hFFFF
`define STT_LOW_WORD_TOP 16'hFFFF

// ==========================================================
// Prescaler terminal counts (ratio minus one)
`define STT_PSC_LIM_1 8'h00
`define STT_PSC_LIM_8 8'h07
`define STT_PSC_LIM_64 8'h3F
`define STT_PSC_LIM_256 8'hFF

`endif

// ==== rtl/stt_pkg.sv ====
/*
  Types shared by the three-timer block.
  Assumes the constants header is compiled alongside.
*/
package stt_pkg;
  // Prescale codes of the two-bit field
  typedef enum logic [1:0] {
    STT_DIV1 = 2'h0,
    STT_DIV8 = 2'h1,
    STT_DIV64 = 2'h2,
    STT_DIV256 = 2'h3
  } stt_prescale_t;

  typedef logic [15:0] stt_word_t;
endpackage : stt_pkg

// ==== rtl/stt_timer16.sv ====
/*
  One 16-bit counting unit: prescaler, gate, period wrap and event pulse.
  Assumes inputs already synchronised to mclk by the parent.
*/
`timescale 1ns/1ps
`default_nettype none
`include "stt_defs.svh"
module stt_timer16 (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Configuration
  input wire logic run,
  input wire logic halt,
  input wire logic src_ext,
  input wire logic gate_en,
  input wire stt_pkg::stt_prescale_t prescale,
  input wire logic chained,
  // Stimulus
  input wire logic src_pulse,
  input wire logic gate_lvl,
  input wire logic carry,
  input wire logic at_period,
  // Software write
  input wire logic wr_en,
  input wire stt_pkg::stt_word_t wr_data,
  // Results
  output stt_pkg::stt_word_t count,
  output logic step,
  output logic event_pulse
);
  logic [7:0] psc;
  logic active;
  logic gated;
  logic tick;
  logic gate_d;
  logic gate_fall;

  // Terminal count of the prescaler for a code
  function automatic logic [7:0] psc_limit(input stt_pkg::stt_prescale_t code);
    case (code)
      stt_pkg::STT_DIV1: psc_limit = `STT_PSC_LIM_1;
      stt_pkg::STT_DIV8: psc_limit = `STT_PSC_LIM_8;
      stt_pkg::STT_DIV64: psc_limit = `STT_PSC_LIM_64;
      default: psc_limit = `STT_PSC_LIM_256;
    endcase
  endfunction : psc_limit

  // Qualified input ticks
  assign active = run & ~halt;
  assign gated = gate_en & ~src_ext;
  assign tick = src_pulse & active & (~gated | gate_lvl) & (psc == psc_limit(prescale));
  assign step = chained ? (active & carry) : tick;
  assign gate_fall = gate_d & ~gate_lvl & gated & active & ~chained;

  // Prescaler; cleared while stopped so a restart begins a full period
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      psc <= 8'h00;
    end else if (!active) begin
      psc <= 8'h00;
    end else if (src_pulse && (~gated || gate_lvl)) begin
      psc <= (psc == psc_limit(prescale)) ? 8'h00 : psc + 8'h01;
    end
  end

  // Counter; a software write wins over a hardware step
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= `STT_CNT_RESET;
    end else if (wr_en) begin
      count <= wr_data;
    end else if (step) begin
      count <= at_period ? `STT_CNT_RESET : count + 16'h0001;
    end
  end

  // Period match or gate falling edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gate_d <= 1'b0;
      event_pulse <= 1'b0;
    end else begin
      gate_d <= gate_lvl;
      event_pulse <= (step & at_period) | gate_fall;
    end
  end
endmodule : stt_timer16
`default_nettype wire

// ==== rtl/stt_timers.sv ====
/*
  Three general timers behind an APB slave: a primary 16-bit timer and
  a second/third pair that can join into one 32-bit timer.
  Assumes a 100 MHz mclk as instruction clock, pins asynchronous to it,
  and cpu_idle driven by logic on mclk.
*/
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "stt_defs.svh"
module stt_timers (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device power state
  input wire logic cpu_idle,
  // External clock pins
  input wire logic primary_external_clock_pin,
  input wire logic second_external_clock_pin,
  input wire logic third_external_clock_pin,
  // Gate pins
  input wire logic primary_gate_pin,
  input wire logic second_gate_pin,
  input wire logic third_gate_pin,
  // Events
  output logic primary_event,
  output logic second_event,
  output logic third_event,
  output logic conv_trigger,
  // Time bases for capture and compare
  output logic [15:0] second_time_base,
  output logic [15:0] third_time_base
);
  localparam int NT = 3;

  // ==========================================================
  // Register state
  stt_pkg::stt_word_t ctl [NT];
  stt_pkg::stt_word_t period [NT];
  stt_pkg::stt_word_t cnt [NT];
  stt_pkg::stt_word_t eff [NT];
  logic [NT-1:0] step;
  logic [NT-1:0] ev;
  logic [NT-1:0] cnt_wr;
  logic [3:0] sel;
  logic wr_fire;
  logic combine;
  logic comb_match;
  logic [NT-1:0] self_match;

  // ==========================================================
  // Pin synchronisers
  logic [5:0] pin_raw;
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic [5:0] sync3;
  logic sync4;
  logic [NT-1:0] ext_edge;
  logic primary_sync_edge;

  // Per-unit derived controls
  logic [NT-1:0] run_v;
  logic [NT-1:0] halt_v;
  logic [NT-1:0] src_v;
  logic [NT-1:0] gate_en_v;
  logic [NT-1:0] pulse_v;
  logic [NT-1:0] gate_lvl_v;
  logic [NT-1:0] carry_v;
  logic [NT-1:0] at_per_v;
  logic [NT-1:0] chain_v;
  stt_pkg::stt_prescale_t psc_v [NT];

  // Map an address to a register index; 4'hF marks a hole
  function automatic logic [3:0] reg_index(input logic [7:0] addr);
    if (addr[1:0] != 2'h0) begin
      reg_index = 4'hF;
    end else if (addr > `STT_OFS_THIRD_PER) begin
      reg_index = 4'hF;
    end else begin
      reg_index = addr[5:2];
    end
  endfunction : reg_index

  // Writable bits of each control register
  function automatic stt_pkg::stt_word_t ctl_mask(input int unit);
    if (unit == 0) begin
      ctl_mask = `STT_PRIMARY_MASK;
    end else if (unit == 1) begin
      ctl_mask = `STT_SECOND_MASK;
    end else begin
      ctl_mask = `STT_THIRD_MASK;
    end
  endfunction : ctl_mask

  // ==========================================================
  // APB slave
  assign sel = reg_index(paddr);
  assign wr_fire = psel & penable & pready & pwrite & (sel != 4'hF);

  // No wait states: answer is prepared in the setup cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (sel == 4'hF);
    end
  end

  // Read data captured at setup so prdata leaves a flop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      if (pwrite || sel == 4'hF) begin
        prdata <= 32'h0000_0000;
      end else begin
        // One decoder for every slot keeps the map in a single place
        prdata <= {16'h0000, sel_word(sel)};
      end
    end
  end

  // Index to word for every slot
  function automatic stt_pkg::stt_word_t sel_word(input logic [3:0] idx);
    logic [3:0] unit;
    logic [3:0] part;
    unit = idx / 4'h3;
    part = idx - unit * 4'h3;
    if (unit > 4'h2) begin
      sel_word = 16'h0000;
    end else if (part == 4'h0) begin
      sel_word = ctl[unit[1:0]];
    end else if (part == 4'h1) begin
      sel_word = cnt[unit[1:0]];
    end else begin
      sel_word = period[unit[1:0]];
    end
  endfunction : sel_word

  // ==========================================================
  // Control and period registers, one set per unit
  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++) begin : g_regs
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          ctl[gi] <= `STT_CTL_RESET;
        end else if (wr_fire && sel == 4'(3 * gi)) begin
          ctl[gi] <= pwdata[15:0] & ctl_mask(gi);
        end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          period[gi] <= `STT_PER_RESET;
        end else if (wr_fire && sel == 4'(3 * gi + 2)) begin
          period[gi] <= pwdata[15:0];
        end
      end

      assign cnt_wr[gi] = wr_fire && sel == 4'(3 * gi + 1);
      assign self_match[gi] = cnt[gi] == period[gi];
    end
  endgenerate

  // ==========================================================
  // Pin synchronisers; third stage feeds edge detection only
  assign pin_raw = {third_gate_pin, second_gate_pin, primary_gate_pin,
                    third_external_clock_pin, second_external_clock_pin, primary_external_clock_pin};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
      sync3 <= 6'h00;
      sync4 <= 1'b0;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      sync4 <= sync3[0];
    end
  end

  // Rising edges of the clock pins
  assign ext_edge = sync2[2:0] & ~sync3[2:0];
  // Extra resampling stage when synchronisation is asked for
  assign primary_sync_edge = sync3[0] & ~sync4;

  // ==========================================================
  // Joined-pair controls
  assign combine = ctl[1][`STT_COMBINE_BIT];
  assign comb_match = {cnt[2], cnt[1]} == {period[2], period[1]};

  // Third unit takes the second unit's controls while joined
  always_comb begin
    eff[0] = ctl[0];
    eff[1] = ctl[1];
    eff[2] = combine ? ctl[1] : ctl[2];
  end

  // Per-unit clock, gate and period selection
  always_comb begin
    for (int i = 0; i < NT; i++) begin
      run_v[i] = eff[i][`STT_RUN_BIT];
      halt_v[i] = eff[i][`STT_IDLE_STOP_BIT] & cpu_idle;
      src_v[i] = eff[i][`STT_SRC_BIT];
      gate_en_v[i] = eff[i][`STT_GATE_BIT];
      psc_v[i] = stt_pkg::stt_prescale_t'(eff[i][`STT_PSC_HI:`STT_PSC_LO]);
      gate_lvl_v[i] = sync2[3 + i];
      pulse_v[i] = src_v[i] ? ext_edge[i] : 1'b1;
      at_per_v[i] = self_match[i];
      carry_v[i] = 1'b0;
      chain_v[i] = 1'b0;
    end
    // Primary chooses synchronised or direct pin edges
    if (src_v[0] && eff[0][`STT_SYNC_BIT]) begin
      pulse_v[0] = primary_sync_edge;
    end
    if (combine) begin
      // Low word wraps freely below the joined match
      at_per_v[1] = comb_match;
      at_per_v[2] = comb_match;
      chain_v[2] = 1'b1;
      carry_v[2] = step[1] & ((cnt[1] == `STT_LOW_WORD_TOP) | comb_match);
    end
  end

  // ==========================================================
  // Counting units
  generate
    for (gi = 0; gi < NT; gi++) begin : g_unit
      stt_timer16 u_timer (
        .mclk(mclk),
        .rst_n(rst_n),
        .run(run_v[gi]),
        .halt(halt_v[gi]),
        .src_ext(src_v[gi]),
        .gate_en(gate_en_v[gi]),
        .prescale(psc_v[gi]),
        .chained(chain_v[gi]),
        .src_pulse(pulse_v[gi]),
        .gate_lvl(gate_lvl_v[gi]),
        .carry(carry_v[gi]),
        .at_period(at_per_v[gi]),
        .wr_en(cnt_wr[gi]),
        .wr_data(pwdata[15:0]),
        .count(cnt[gi]),
        .step(step[gi]),
        .event_pulse(ev[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Event outputs
  // Joined pair reports through the third event only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      primary_event <= 1'b0;
      second_event <= 1'b0;
      third_event <= 1'b0;
    end else begin
      primary_event <= ev[0];
      second_event <= combine ? 1'b0 : ev[1];
      third_event <= combine ? ev[1] : ev[2];
    end
  end

  // Converter trigger: joined period match only, never a gate edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      conv_trigger <= 1'b0;
    end else begin
      conv_trigger <= combine & step[1] & comb_match;
    end
  end

  // ==========================================================
  // Time bases straight from the unit count flops
  assign second_time_base = cnt[1];
  assign third_time_base = cnt[2];
endmodule : stt_timers
`default_nettype wire
